// *** tb/tb_top.sv ***
// self-checking bench for the split-capable auto-reload timer
// assumes split_timer and split_timer_pkg are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       timer_irq_enable = 1'b0;
  logic       hi_fast = 1'b0;
  logic       lo_fast = 1'b0;
  logic       ext_osc = 1'b0;
  logic       irq_req;
  int         errors = 0;
  int         comparisons = 0;
  logic [7:0] rl;
  logic [7:0] rh;
  logic [7:0] v;
  split_timer split_timer_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .high_byte_fast_clock_select(hi_fast),
    .low_byte_fast_clock_select(lo_fast), .ext_osc(ext_osc), .irq_req(irq_req)
  );
  always #5 clk_sys = ~clk_sys;
  // external oscillator, unrelated phase, four core cycles per period
  initial
  begin
    #7;
    forever #20 ext_osc = ~ext_osc;
  end
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] in_rng(input logic [7:0] x, input int lo, input int hi);
    return {7'h00, (x >= lo) && (x <= hi)};
  endfunction : in_rng
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [7:0] old, output logic [7:0] d);
    d = old;
    for (int i = 0; i < 40 && d === old; i++)
      rd(a, d);
  endtask : poll
  initial
  begin
    #400000;
    errors++;
    finish_test();
  end
  initial
  begin
    logic [7:0] addrs [6];
    addrs = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
    void'($urandom(32'h0379));
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    foreach (addrs[i])
    begin
      rd(addrs[i], v);
      check(v, 8'h00);
    end
    // reload values never 0xff, so a poll always sees the reload land
    rl = 8'($urandom) & 8'h7f;
    rh = 8'($urandom % 255);
    wr(8'hca, rl);
    wr(8'hcb, rh);
    rd(8'hca, v);
    check(v, rl);
    rd(8'hcb, v);
    check(v, rh);
    wr(8'hc8, 8'h3a);
    rd(8'hc8, v);
    check(v, 8'h28);
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    repeat (30) @(posedge clk_sys);
    rd(8'hcc, v);
    check(v, 8'hff);
    timer_irq_enable = 1'b1;
    wr(8'hc8, 8'h04);
    poll(8'hcc, 8'hff, v);
    check(v, rl);
    rd(8'hcd, v);
    check(v, rh);
    rd(8'hc8, v);
    check(v, 8'hc4);
    check({7'h00, irq_req}, 8'h01);
    wr(8'hc8, 8'h80);
    repeat (30) @(posedge clk_sys);
    rd(8'hc8, v);
    check(v, 8'h80);
    check({7'h00, irq_req}, 8'h01);
    wr(8'hc8, 8'h00);
    rd(8'hc8, v);
    check(v, 8'h00);
    check({7'h00, irq_req}, 8'h00);
    // split mode: low overflow without, then with its interrupt enable
    wr(8'hc8, 8'h08);
    wr(8'hcd, 8'h40);
    wr(8'hcc, 8'hff);
    poll(8'hcc, 8'hff, v);
    check(v, rl);
    rd(8'hc8, v);
    check(v, 8'h48);
    check({7'h00, irq_req}, 8'h00);
    wr(8'hc8, 8'h28);
    wr(8'hcc, 8'hff);
    poll(8'hcc, 8'hff, v);
    check(v, rl);
    rd(8'hcd, v);
    check(v, 8'h40);
    rd(8'hc8, v);
    check(v, 8'h68);
    check({7'h00, irq_req}, 8'h01);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h0c);
    poll(8'hcd, 8'hff, v);
    check(v, rh);
    rd(8'hc8, v);
    check(v, 8'h8c);
    // clock sources, 16-bit mode, low byte counted from zero
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'h00);
    lo_fast = 1'b1;
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (20) @(posedge clk_sys);
    wr(8'hc8, 8'h00);
    rd(8'hcc, v);
    check(in_rng(v, 18, 24), 8'h01);
    lo_fast = 1'b0;
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (240) @(posedge clk_sys);
    wr(8'hc8, 8'h00);
    rd(8'hcc, v);
    check(in_rng(v, 19, 21), 8'h01);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h05);
    repeat (320) @(posedge clk_sys);
    wr(8'hc8, 8'h01);
    rd(8'hcc, v);
    check(in_rng(v, 9, 11), 8'h01);
    // split mode: per-byte clock choice, low byte free of run control
    hi_fast = 1'b1;
    lo_fast = 1'b1;
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h08);
    repeat (20) @(posedge clk_sys);
    rd(8'hcc, v);
    check(in_rng(v, 18, 24), 8'h01);
    rd(8'hcd, v);
    check(v, 8'h00);
    lo_fast = 1'b0;
    wr(8'hc8, 8'h09);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h0d);
    repeat (20) @(posedge clk_sys);
    wr(8'hc8, 8'h09);
    rd(8'hcd, v);
    check(in_rng(v, 18, 24), 8'h01);
    rd(8'hcc, v);
    check(in_rng(v, 0, 1), 8'h01);
    // reset in mid-run clears every register again
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    check({7'h00, irq_req}, 8'h00);
    foreach (addrs[i])
    begin
      rd(addrs[i], v);
      check(v, 8'h00);
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// *** verilog/split_timer.sv ***
// split-capable 16-bit auto-reload timer with its control and reload registers
// assumes sfr_wr/sfr_rd are one-cycle strobes on clk_sys; ext_osc is asynchronous
`timescale 1ns/1ps
`default_nettype none
module split_timer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer_irq_enable,
  input  wire logic       high_byte_fast_clock_select,
  input  wire logic       low_byte_fast_clock_select,
  input  wire logic       ext_osc,
  output logic            irq_req
);
  logic [7:0] control_r, control_nxt;
  logic [7:0] reload_low_r, reload_low_nxt;
  logic [7:0] reload_high_r, reload_high_nxt;
  logic [7:0] count_low_r, count_low_nxt;
  logic [7:0] count_high_r, count_high_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       irq_r, irq_nxt;
  logic [3:0] div12_r, div12_nxt;
  logic [2:0] osc_sync_r, osc_sync_nxt;
  logic       osc_level_r, osc_level_nxt;
  logic [2:0] div8_r, div8_nxt;
  logic       osc_rise;
  logic       tick12, tick_ext, tick_sel, tick_low, tick_high;
  logic       split, run, low_wrap, high_wrap, set_high, set_low;

  function automatic logic is_wr(input logic [7:0] a);
    is_wr = sfr_wr && (sfr_addr == a);
  endfunction : is_wr

  assign split    = control_r[split_timer_pkg::BIT_SPLIT];
  assign run      = control_r[split_timer_pkg::BIT_RUN];
  assign tick12   = (div12_r == split_timer_pkg::DIV12_LAST);
  // external edge counted once second and third stage agree
  assign osc_rise = (osc_sync_r[1] == osc_sync_r[2]) && (osc_sync_r[2] != osc_level_r)
                    && osc_sync_r[2];
  // one tick per eight agreed rising edges
  assign tick_ext = osc_rise && (div8_r == split_timer_pkg::DIV8_LAST);
  assign tick_sel = control_r[split_timer_pkg::BIT_EXT_CLK] ? tick_ext : tick12;
  assign tick_low  = low_byte_fast_clock_select ? 1'b1 : tick_sel;
  assign tick_high = split ? (high_byte_fast_clock_select ? 1'b1 : tick_sel) : tick_low;
  assign low_wrap  = tick_low && (split || run) && (count_low_r == 8'hff);
  assign high_wrap = split ? (run && tick_high && count_high_r == 8'hff)
                           : (low_wrap && count_high_r == 8'hff);
  assign set_high  = high_wrap;
  assign set_low   = low_wrap;

  always_comb
  begin
    div12_nxt     = tick12 ? 4'h0 : div12_r + 4'h1;
    osc_sync_nxt  = {osc_sync_r[1:0], ext_osc};
    osc_level_nxt = (osc_sync_r[1] == osc_sync_r[2]) ? osc_sync_r[2] : osc_level_r;
    div8_nxt      = div8_r;
    if (osc_rise)
      div8_nxt = div8_r + 3'h1;
  end

  always_comb
  begin
    control_nxt     = control_r;
    reload_low_nxt  = reload_low_r;
    reload_high_nxt = reload_high_r;
    count_low_nxt   = count_low_r;
    count_high_nxt  = count_high_r;
    if (is_wr(split_timer_pkg::ADDR_CONTROL))
      control_nxt = sfr_wdata & split_timer_pkg::CONTROL_WRITE_MASK;
    if (is_wr(split_timer_pkg::ADDR_RELOAD_LOW))
      reload_low_nxt = sfr_wdata;
    if (is_wr(split_timer_pkg::ADDR_RELOAD_HIGH))
      reload_high_nxt = sfr_wdata;
    // set wins over software clear
    if (set_high)
      control_nxt[split_timer_pkg::BIT_HIGH_FLAG] = 1'b1;
    if (set_low)
      control_nxt[split_timer_pkg::BIT_LOW_FLAG] = 1'b1;
    if (split)
    begin
      if (tick_low)
        count_low_nxt = low_wrap ? reload_low_r : count_low_r + 8'h01;
      if (run && tick_high)
        count_high_nxt = high_wrap ? reload_high_r : count_high_r + 8'h01;
    end
    else if (run && tick_low)
    begin
      if (high_wrap)
      begin
        count_low_nxt  = reload_low_r;
        count_high_nxt = reload_high_r;
      end
      else
      begin
        count_low_nxt = count_low_r + 8'h01;
        if (low_wrap)
          count_high_nxt = count_high_r + 8'h01;
      end
    end
    // software write to count wins the cycle
    if (is_wr(split_timer_pkg::ADDR_COUNT_LOW))
      count_low_nxt = sfr_wdata;
    if (is_wr(split_timer_pkg::ADDR_COUNT_HIGH))
      count_high_nxt = sfr_wdata;
    irq_nxt = timer_irq_enable && (control_nxt[split_timer_pkg::BIT_HIGH_FLAG]
              || (control_nxt[split_timer_pkg::BIT_LOW_FLAG]
                  && control_nxt[split_timer_pkg::BIT_LOW_IRQ_EN]));
    rdata_nxt = rdata_r;
    if (sfr_rd)
    begin
      case (sfr_addr)
        split_timer_pkg::ADDR_CONTROL:     rdata_nxt = control_r;
        split_timer_pkg::ADDR_RELOAD_LOW:  rdata_nxt = reload_low_r;
        split_timer_pkg::ADDR_RELOAD_HIGH: rdata_nxt = reload_high_r;
        split_timer_pkg::ADDR_COUNT_LOW:   rdata_nxt = count_low_r;
        split_timer_pkg::ADDR_COUNT_HIGH:  rdata_nxt = count_high_r;
        default:                           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      control_r     <= split_timer_pkg::RESET_BYTE;
      reload_low_r  <= split_timer_pkg::RESET_BYTE;
      reload_high_r <= split_timer_pkg::RESET_BYTE;
      count_low_r   <= split_timer_pkg::RESET_BYTE;
      count_high_r  <= split_timer_pkg::RESET_BYTE;
      rdata_r       <= 8'h00;
      irq_r         <= 1'b0;
      div12_r       <= 4'h0;
      osc_sync_r    <= 3'h0;
      osc_level_r   <= 1'b0;
      div8_r        <= 3'h0;
    end
    else
    begin
      control_r     <= control_nxt;
      reload_low_r  <= reload_low_nxt;
      reload_high_r <= reload_high_nxt;
      count_low_r   <= count_low_nxt;
      count_high_r  <= count_high_nxt;
      rdata_r       <= rdata_nxt;
      irq_r         <= irq_nxt;
      div12_r       <= div12_nxt;
      osc_sync_r    <= osc_sync_nxt;
      osc_level_r   <= osc_level_nxt;
      div8_r        <= div8_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign irq_req   = irq_r;

  property p_high_flag_set;
    @(posedge clk_sys) disable iff (!reset_n)
    high_wrap |=> control_r[split_timer_pkg::BIT_HIGH_FLAG];
  endproperty
  a_high_flag_set: assert property (p_high_flag_set) else $error("high flag not set");

  property p_full_wrap;
    @(posedge clk_sys) disable iff (!reset_n)
    (!split && run && tick_low && count_low_r == 8'hff && count_high_r == 8'hff
     && !sfr_wr) |=> (count_low_r == $past(reload_low_r)
     && count_high_r == $past(reload_high_r) && control_r[split_timer_pkg::BIT_HIGH_FLAG]);
  endproperty
  a_full_wrap: assert property (p_full_wrap) else $error("16-bit wrap wrong");

  property p_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    // request follows the enable input one clock late
    ($past(timer_irq_enable) && control_r[split_timer_pkg::BIT_HIGH_FLAG]) |-> irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_no_self_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (control_r[split_timer_pkg::BIT_HIGH_FLAG] && !is_wr(split_timer_pkg::ADDR_CONTROL))
    |=> control_r[split_timer_pkg::BIT_HIGH_FLAG];
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("flag self-cleared");

  property p_low_kept;
    @(posedge clk_sys) disable iff (!reset_n)
    (control_r[split_timer_pkg::BIT_LOW_FLAG] && !is_wr(split_timer_pkg::ADDR_CONTROL))
    |=> control_r[split_timer_pkg::BIT_LOW_FLAG];
  endproperty
  a_low_kept: assert property (p_low_kept) else $error("low flag self-cleared");

  property p_low_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    low_wrap |=> control_r[split_timer_pkg::BIT_LOW_FLAG];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set");

  property p_low_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    ($past(timer_irq_enable) && control_r[split_timer_pkg::BIT_LOW_FLAG]
     && control_r[split_timer_pkg::BIT_LOW_IRQ_EN]) |-> irq_req;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low irq missing");

  property p_irq_quiet;
    @(posedge clk_sys) disable iff (!reset_n)
    !(control_r[split_timer_pkg::BIT_HIGH_FLAG] || control_r[split_timer_pkg::BIT_LOW_FLAG])
    |-> !irq_req;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    control_r[4] == 1'b0 && control_r[1] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_hold_stopped;
    @(posedge clk_sys) disable iff (!reset_n)
    (!run && !sfr_wr) |=> $stable(count_high_r);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("count moved stopped");

  property p_split_low_runs;
    @(posedge clk_sys) disable iff (!reset_n)
    (split && !run && low_byte_fast_clock_select && !sfr_wr && count_low_r != 8'hff)
    |=> count_low_r == $past(count_low_r) + 8'h01;
  endproperty
  a_split_low_runs: assert property (p_split_low_runs) else $error("low byte stalled");
endmodule : split_timer
`default_nettype wire

// *** verilog/split_timer_pkg.sv ***
// constants for the split-capable auto-reload timer
// assumes an sfr bus with byte address, one-cycle write and read strobes
// Operation
// - high overflow flag on high byte wrap
// - 16-bit mode: flag on full wrap
// - interrupt request when high flag set
// - flags cleared only by software writing zero or by reset
// - low flag on low byte wrap, always
// - low overflow also interrupts when enabled
// - control bits 4 and 1 read zero
// - split select chooses 16-bit or two 8-bit
// - run control gates counting
// - split mode: run gates high byte only
// - ext select: core clock/12 or ext/8
// - one ext select, per-byte fast override
// - low reload register at 0xca, reset zero
// - high reload register at 0xcb, reset zero
// - 16-bit wrap loads full reload value
// - split mode: each byte reloads itself
// - fast select forces core clock per byte in split mode; in 16-bit mode the low select drives both bytes
// - both overflows share one interrupt request
package split_timer_pkg;
  localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;
  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_EXT_CLK    = 0;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hed;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [3:0] DIV12_LAST         = 4'hb;
  localparam logic [2:0] DIV8_LAST          = 3'h7;
endpackage : split_timer_pkg
